// *** rtl/plrw_pkg.sv ***
`default_nettype none

// ============================================================
// Shared constants and types for the port latch block.
package plrw_pkg;

    // Default number of bits in one port.
    localparam int PLRW_WIDTH = 8;

    // Value of each output latch bit after reset.
    localparam logic PLRW_LATCH_RST = 1'h0;

    // Value of each direction bit after reset (input mode).
    localparam logic PLRW_DIR_RST = 1'h1;

    // Direction encoding of one port bit.
    localparam logic PLRW_DIR_OUT = 1'h0;
    localparam logic PLRW_DIR_IN = 1'h1;

    // Operations that a read-modify-write access can apply.
    typedef enum logic [1:0] {
        PLRW_OP_AND,
        PLRW_OP_OR,
        PLRW_OP_XOR,
        PLRW_OP_ADD
    } plrw_op_t;

    // Strobes of one processor access, all one-cycle pulses.
    typedef struct packed {
        logic wr;
        logic rd;
        logic rmw;
        logic dir_wr;
        plrw_op_t op;
    } plrw_req_t;

endpackage : plrw_pkg

`default_nettype wire

// *** rtl/plrw_port.sv ***
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// [R1] In output mode a write loads the latch and the pin is driven from it.
// [R2] In input mode a write still loads the latch while the driver stays off.
// [R3] The latch keeps its value until the next write or operation result.
// [R4] Reset clears every latch bit to zero whatever the direction.
// [R5] In output mode a read returns the latch and leaves it unchanged.
// [R6] In input mode a read returns the pin level and leaves the latch alone.
// [R7] In output mode an operation works on the latch and stores the result.
// [R8] In input mode an operation works on the pin and stores into the latch.
// [R9] Each bit has a direction bit where one means input and zero output.
module plrw_port #(
    parameter int WIDTH = plrw_pkg::PLRW_WIDTH
) (
    input wire logic i_clock,
    input wire logic i_rst,
    input wire plrw_pkg::plrw_req_t i_req,
    input wire logic [WIDTH-1:0] i_wr_data,
    input wire logic [WIDTH-1:0] i_dir_data,
    input wire logic [WIDTH-1:0] i_pin_in,
    output logic [WIDTH-1:0] o_pin_out,
    output logic [WIDTH-1:0] o_pin_oe,
    output logic [WIDTH-1:0] o_rd_data,
    output logic o_rd_valid
);

    // ========================================================
    // Operation unit

    // Applies the selected operation to the source and operand.
    function automatic logic [WIDTH-1:0] plrw_alu(
        input plrw_pkg::plrw_op_t op,
        input logic [WIDTH-1:0] src,
        input logic [WIDTH-1:0] arg
    );
        logic [WIDTH-1:0] res;
        res = '0;
        case (op)
            plrw_pkg::PLRW_OP_AND: res = src & arg;
            plrw_pkg::PLRW_OP_OR: res = src | arg;
            plrw_pkg::PLRW_OP_XOR: res = src ^ arg;
            default: res = src + arg;
        endcase
        return res;
    endfunction

    // ========================================================
    // State

    logic [WIDTH-1:0] latch_q;
    logic [WIDTH-1:0] latch_d;
    logic [WIDTH-1:0] dir_q;
    logic [WIDTH-1:0] dir_d;
    logic [WIDTH-1:0] oe_q;
    logic [WIDTH-1:0] oe_d;
    logic [WIDTH-1:0] rd_data_q;
    logic [WIDTH-1:0] rd_data_d;
    logic rd_valid_q;
    logic rd_valid_d;
    logic [WIDTH-1:0] src;

    // ========================================================
    // Per-bit source select

    // Input bits show the pin, output bits show their own latch.
    genvar gi;
    generate
        for (gi = 0; gi < WIDTH; gi++) begin : g_src
            always_comb begin
                if (dir_q[gi] == plrw_pkg::PLRW_DIR_IN) begin
                    src[gi] = i_pin_in[gi]; // [R6] [R8]
                end else begin
                    src[gi] = latch_q[gi]; // [R5] [R7]
                end
            end
        end
    endgenerate

    // ========================================================
    // Next-state logic

    // A plain write wins over an operation issued in the same cycle.
    always_comb begin
        latch_d = latch_q; // [R3]
        dir_d = dir_q;
        rd_data_d = rd_data_q;
        rd_valid_d = 1'h0;
        if (i_req.wr) begin
            latch_d = i_wr_data; // [R1] [R2]
        end else if (i_req.rmw) begin
            latch_d = plrw_alu(i_req.op, src, i_wr_data); // [R7] [R8]
        end
        if (i_req.dir_wr) begin
            dir_d = i_dir_data; // [R9]
        end
        if (i_req.rd) begin
            rd_data_d = src; // [R5] [R6]
            rd_valid_d = 1'h1;
        end
        oe_d = ~dir_d; // [R1] [R2] [R9]
    end

    // Registers; reset clears the latch and sets every bit to input.
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            latch_q <= {WIDTH{plrw_pkg::PLRW_LATCH_RST}}; // [R4]
            dir_q <= {WIDTH{plrw_pkg::PLRW_DIR_RST}};
            oe_q <= {WIDTH{~plrw_pkg::PLRW_DIR_RST}};
            rd_data_q <= '0;
            rd_valid_q <= 1'h0;
        end else begin
            latch_q <= latch_d;
            dir_q <= dir_d;
            oe_q <= oe_d;
            rd_data_q <= rd_data_d;
            rd_valid_q <= rd_valid_d;
        end
    end

    // Outputs come straight from the registers.
    assign o_pin_out = latch_q; // [R1]
    assign o_pin_oe = oe_q;
    assign o_rd_data = rd_data_q;
    assign o_rd_valid = rd_valid_q;

    // ========================================================
    // Checks

    sequence s_write;
        i_req.wr;
    endsequence

    sequence s_read;
        i_req.rd;
    endsequence

    sequence s_modify;
        i_req.rmw && !i_req.wr;
    endsequence

    sequence s_quiet;
        !i_req.wr && !i_req.rmw;
    endsequence

    sequence s_clash;
        i_req.wr && i_req.rmw;
    endsequence

    a_write_loads: assert property ( // [R1]
        @(posedge i_clock) disable iff (i_rst)
        s_write |=> (o_pin_out == $past(i_wr_data)))
        else $error("Write did not load the latch.");

    a_driver_follows_dir: assert property ( // [R2]
        @(posedge i_clock) disable iff (i_rst)
        s_write and !i_req.dir_wr |=> $stable(o_pin_oe)
            && ((o_pin_oe & $past(dir_q)) == '0))
        else $error("Write changed the driver of an input bit.");

    a_write_beats_op: assert property ( // [R1]
        @(posedge i_clock) disable iff (i_rst)
        s_clash |=> (latch_q == $past(i_wr_data)))
        else $error("Operation overrode a write in the same cycle.");

    a_read_pulse: assert property ( // [R5]
        @(posedge i_clock) disable iff (i_rst)
        !i_req.rd |=> !o_rd_valid && $stable(o_rd_data))
        else $error("Read answer changed without a read.");

    a_reset_undriven: assert property ( // [R9]
        @(posedge i_clock)
        i_rst |-> (o_pin_oe == '0) && (o_rd_valid == 1'h0))
        else $error("Pins driven or read pending under reset.");

    a_latch_holds: assert property ( // [R3]
        @(posedge i_clock) disable iff (i_rst)
        s_quiet ##1 s_quiet |=> $stable(o_pin_out) && $stable(latch_q))
        else $error("Latch changed without a write.");

    a_reset_clears: assert property ( // [R4]
        @(posedge i_clock)
        i_rst |-> (latch_q == '0) && (o_pin_out == '0))
        else $error("Latch not cleared under reset.");

    a_read_out_bits: assert property ( // [R5]
        @(posedge i_clock) disable iff (i_rst)
        s_read |=> o_rd_valid
            && ((o_rd_data & ~$past(dir_q)) == ($past(latch_q) & ~$past(dir_q))))
        else $error("Output bit read did not return the latch.");

    a_read_in_bits: assert property ( // [R6]
        @(posedge i_clock) disable iff (i_rst)
        s_read |=> o_rd_valid
            && ((o_rd_data & $past(dir_q)) == ($past(i_pin_in) & $past(dir_q))))
        else $error("Input bit read did not return the pin.");

    a_read_no_change: assert property ( // [R5]
        @(posedge i_clock) disable iff (i_rst)
        s_read and s_quiet |=> (latch_q == $past(latch_q)))
        else $error("Read altered the latch.");

    a_rmw_out_bits: assert property ( // [R7]
        @(posedge i_clock) disable iff (i_rst)
        s_modify |=> ((latch_q & ~$past(dir_q)) ==
            (plrw_alu($past(i_req.op), $past(latch_q), $past(i_wr_data))
            & ~$past(dir_q))))
        else $error("Output bit operation used the wrong source.");

    a_rmw_in_bits: assert property ( // [R8]
        @(posedge i_clock) disable iff (i_rst)
        s_modify and !i_req.dir_wr |=> ((latch_q & dir_q) ==
            (plrw_alu($past(i_req.op), $past(src), $past(i_wr_data))
            & dir_q)) && ((o_pin_oe & dir_q) == '0))
        else $error("Input bit operation wrong or pin driven.");

    a_dir_write: assert property ( // [R9]
        @(posedge i_clock) disable iff (i_rst)
        i_req.dir_wr |=> (dir_q == $past(i_dir_data))
            && (o_pin_oe == ~$past(i_dir_data)))
        else $error("Direction write not applied.");

endmodule // plrw_port

`default_nettype wire

// *** bench/plrw_pin_model.sv ***
`timescale 1ns/1ps
`default_nettype none

// ============================================================
// Pin model: a driven bit shows the latch, an undriven bit the outside.
module plrw_pin_model #(
    parameter int WIDTH = 8
) (
    input wire logic [WIDTH-1:0] i_pin_out,
    input wire logic [WIDTH-1:0] i_pin_oe,
    input wire logic [WIDTH-1:0] i_ext,
    output logic [WIDTH-1:0] o_pin
);
    // Resolve each wire from the enable of the port driver.
    assign o_pin = (i_pin_oe & i_pin_out) | (~i_pin_oe & i_ext);
endmodule // plrw_pin_model

`default_nettype wire

// *** bench/testbench.sv ***
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin comparisons++; if ((s) !== (e)) begin errors++; \
    $display("MISMATCH %s exp %h got %h", n, e, s); end end

// ============================================================
// Self-checking bench for the port latch block.
module testbench;
    logic i_clock = 1'h0;
    logic i_rst = 1'h0;
    plrw_pkg::plrw_req_t req = '0;
    logic [7:0] wr_d = 8'h00;
    logic [7:0] ext = 8'h96;
    logic [7:0] pin, pout, poe, rdat, lat;
    logic rval;
    int errors = 0;
    int comparisons = 0;

    plrw_port dut_u (.i_clock(i_clock), .i_rst(i_rst), .i_req(req),
        .i_wr_data(wr_d), .i_dir_data(wr_d), .i_pin_in(pin),
        .o_pin_out(pout), .o_pin_oe(poe), .o_rd_data(rdat),
        .o_rd_valid(rval));
    plrw_pin_model pin_u (.i_pin_out(pout), .i_pin_oe(poe), .i_ext(ext),
        .o_pin(pin));

    // Clock of 100 ns period.
    initial forever #50 i_clock = ~i_clock;

    // Prints the verdict and ends the run.
    task automatic test_done();
        if (errors == 0 && comparisons > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    // Expected result of one operation.
    function automatic logic [7:0] calc(input int op, input logic [7:0] a,
        input logic [7:0] b);
        case (op)
            0: return a & b;
            1: return a | b;
            2: return a ^ b;
            default: return a + b;
        endcase
    endfunction

    // One access pulse, strobes wr rd rmw dir_wr, after one idle cycle.
    task automatic access(input logic [3:0] s, input int op,
        input logic [7:0] d);
        @(negedge i_clock);
        req = {s, plrw_pkg::plrw_op_t'(op)};
        wr_d = d;
        @(negedge i_clock);
        req = '0;
    endtask

    // Output mode: write, hold, read back.
    task automatic t_out();
        access(4'h1, 0, 8'h00);
        `CHK("oe", 8'hFF, poe)
        access(4'h8, 0, 8'hA5);
        `CHK("latch", 8'hA5, pout)
        repeat (3) @(negedge i_clock);
        `CHK("latch", 8'hA5, pout)
        access(4'h4, 0, 8'h00);
        `CHK("valid", 1'h1, rval)
        `CHK("rdata", 8'hA5, rdat)
        `CHK("latch", 8'hA5, pout)
    endtask

    // Input mode: write keeps driver off, read returns the pin.
    task automatic t_in();
        access(4'h1, 0, 8'hFF);
        `CHK("oe", 8'h00, poe)
        access(4'h8, 0, 8'h3C);
        `CHK("latch", 8'h3C, pout)
        `CHK("pin", 8'h96, pin)
        access(4'h4, 0, 8'h00);
        `CHK("rdata", 8'h96, rdat)
        `CHK("latch", 8'h3C, pout)
    endtask

    // Operations on the pin, then on the latch, for every operation.
    task automatic t_rmw();
        for (int op = 0; op < 4; op++) begin
            access(4'h2, op, 8'h5A);
            `CHK("rmw_in", calc(op, 8'h96, 8'h5A), pout)
            `CHK("oe", 8'h00, poe)
        end
        access(4'h1, 0, 8'h00);
        access(4'hA, 1, 8'h0F);
        `CHK("wr_wins", 8'h0F, pout)
        lat = 8'h0F;
        for (int op = 0; op < 4; op++) begin
            lat = calc(op, lat, 8'hC3);
            access(4'h2, op, 8'hC3);
            `CHK("rmw_out", lat, pout)
        end
    endtask

    // Reset in mid-run clears the latch in output mode.
    task automatic t_reset_mid();
        i_rst = 1'h1;
        @(negedge i_clock);
        `CHK("latch", 8'h00, pout)
        `CHK("oe", 8'h00, poe)
        i_rst = 1'h0;
        @(negedge i_clock);
    endtask

    // Main sequence.
    initial begin
        #1 i_rst = 1'h1;
        repeat (4) @(negedge i_clock);
        `CHK("latch", 8'h00, pout)
        i_rst = 1'h0;
        @(negedge i_clock);
        t_out();
        t_in();
        t_rmw();
        t_reset_mid();
        test_done();
    end

    // Watchdog far beyond the few dozen cycles the tests need.
    initial begin
        #100000;
        errors++;
        test_done();
    end
endmodule // testbench

`default_nettype wire
